/* hw/txrxc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_ptr_q[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

/* hw/txrxc_pkg.sv */
// Contract
// - Six-bit amplitude scale field, reset 100001, scales user-programmed transmit pulses.
// - T1/J1 templates: recommended scale 110110, each step moves amplitude 2 percent.
// - E1 templates: recommended scale 100001, each step moves amplitude 3 percent.
// - Writing one to trigger bit 7 starts the selected indirect template access.
// - Direction bit 6: zero writes the template RAM, one reads it.
// - Bits 5-4 pick one of four unit intervals, zero is leftmost.
// - Bits 3-0 pick one of sixteen samples, zero is leftmost.
// - Indirect write stores the seven-bit amplitude field at the addressed sample.
// - Indirect read places the stored sample amplitude into the amplitude field.
// - Receiver power-down bit 4 powers the receiver down; cleared is powered up.
// - Inversion bit 3 makes receive data outputs active low, single or dual rail.
// - Edge bit 2: zero rising, one falling recovered clock; ignored in slicer mode.
// - Mode 00 outputs HDB3/B8ZS decoded single-rail NRZ data.
// - Mode 01 outputs AMI decoded single-rail NRZ data.
// - Mode 10 bypasses decoder, outputs retimed dual-rail NRZ with clock recovery.
// - Mode 11 bypasses recovery and decoder, outputs raw slicer RZ dual-rail data.
// - Registers repeat for eight channels, spaced 0x20, from channel-zero offsets.
package txrxc_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned CH_W = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CH_STRIDE = 32'h20;
  localparam int unsigned OFF_W = 5;
  localparam logic [4:0] OFF_SCALE = 5'h04;
  localparam logic [4:0] OFF_ACCESS = 5'h05;
  localparam logic [4:0] OFF_AMPL = 5'h06;
  localparam logic [4:0] OFF_RXCFG = 5'h07;
  localparam logic [7:0] RST_SCALE = 8'h21;
  localparam logic [7:0] RST_ACCESS = 8'h00;
  localparam logic [7:0] RST_AMPL = 8'h00;
  localparam logic [7:0] RST_RXCFG = 8'h00;
  localparam logic [7:0] MASK_SCALE = 8'h3F;
  localparam logic [7:0] MASK_ACCESS = 8'hFF;
  localparam logic [7:0] MASK_AMPL = 8'h7F;
  localparam logic [7:0] MASK_RXCFG = 8'h1F;
  localparam int unsigned ACC_TRIG_BIT = 7;
  localparam int unsigned ACC_DIR_BIT = 6;
  localparam int unsigned UI_LSB = 4;
  localparam int unsigned UI_W = 2;
  localparam int unsigned SAMPLE_ADDR_LSB = 0;
  localparam int unsigned SAMPLE_ADDR_W = 4;
  localparam int unsigned AMP_W = 7;
  localparam int unsigned SCALE_W = 6;
  localparam int unsigned RX_OFF_BIT = 4;
  localparam int unsigned RX_INV_BIT = 3;
  localparam int unsigned RX_EDGE_BIT = 2;
  localparam int unsigned RX_MD_LSB = 0;
  localparam int unsigned TRAM_DEPTH = NUM_CH << (UI_W + SAMPLE_ADDR_W);
  localparam int unsigned TRAM_AW = CH_W + UI_W + SAMPLE_ADDR_W;
  localparam int SCALE_REF_T1 = 32'h36;
  localparam int SCALE_STEP_T1 = 2;
  localparam int SCALE_REF_E1 = 32'h21;
  localparam int SCALE_STEP_E1 = 3;
  localparam int PCT_FULL = 100;
  localparam int AMP_MAX = 32'h7F;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ACCESS_TIME_NS = 40;
  localparam int unsigned ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMD_FIFO_DEPTH = 32;
  localparam int unsigned CMD_W = ADDR_W + DATA_W;
  typedef enum logic [1:0] {
    RXMD_HDB3 = 2'b00,
    RXMD_AMI = 2'b01,
    RXMD_DUAL = 2'b10,
    RXMD_SLICER = 2'b11
  } txrxc_rxmd_type;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_BUSY = 2'b01,
    ACC_DONE = 2'b10
  } txrxc_acc_type;
endpackage

/* hw/txrxc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_top #(
  parameter int unsigned FIFO_DEPTH = txrxc_pkg::CMD_FIFO_DEPTH,
  parameter int unsigned NUM_CH = txrxc_pkg::NUM_CH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  output logic o_reg_wr_ready,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rdata_valid,
  output logic o_access_busy,
  input wire logic [2:0] i_shaper_ch,
  input wire logic [1:0] i_shaper_ui,
  input wire logic [3:0] i_shaper_sample,
  input wire logic [7:0] i_tx_template_t1,
  output logic [6:0] o_shaper_amplitude,
  input wire logic [7:0] i_rx_recovered_clock,
  input wire logic [7:0] i_rx_nrz_hdb3,
  input wire logic [7:0] i_rx_nrz_ami,
  input wire logic [7:0] i_rx_cdr_pos,
  input wire logic [7:0] i_rx_cdr_neg,
  input wire logic [7:0] i_rx_slicer_pos,
  input wire logic [7:0] i_rx_slicer_neg,
  output logic [7:0] o_rx_power_down,
  output logic [15:0] o_rx_decode_mode,
  output logic [7:0] o_rx_single_rail_out,
  output logic [7:0] o_rx_dual_rail_out_pos,
  output logic [7:0] o_rx_dual_rail_out_neg
);
  localparam int unsigned CW = txrxc_pkg::CH_W;
  localparam int unsigned OW = txrxc_pkg::OFF_W;
  localparam int unsigned AW = txrxc_pkg::AMP_W;
  localparam int unsigned RAW = txrxc_pkg::TRAM_AW;
  localparam int unsigned LW = txrxc_pkg::UI_W + txrxc_pkg::SAMPLE_ADDR_W;
  localparam logic [1:0] ACC_CNT_LAST = 2'(txrxc_pkg::ACCESS_CYCLES - 1);

  if (NUM_CH != txrxc_pkg::NUM_CH || txrxc_pkg::ACCESS_CYCLES > 4) begin : g_chk
    $error("Block serves exactly eight channels and a short RAM access");
  end
  if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_chk_fifo
    $error("Command FIFO depth must be a power of two");
  end

  // Percent scaling around the recommended code of the template family
  function automatic logic [6:0] scale_amp(input logic [6:0] a, input logic [5:0] s,
                                           input logic t1);
    int ref_v;
    int step;
    int pct;
    int prod;
    ref_v = t1 ? txrxc_pkg::SCALE_REF_T1 : txrxc_pkg::SCALE_REF_E1;
    step = t1 ? txrxc_pkg::SCALE_STEP_T1 : txrxc_pkg::SCALE_STEP_E1;
    pct = txrxc_pkg::PCT_FULL + step * (int'(s) - ref_v);
    prod = (int'(a) * pct) / txrxc_pkg::PCT_FULL;
    if (prod < 0) begin
      prod = 0;
    end
    if (prod > txrxc_pkg::AMP_MAX) begin
      prod = txrxc_pkg::AMP_MAX;
    end
    return 7'(prod);
  endfunction

  // Writes queue here so that an indirect access in flight can hold them off
  logic fifo_out_valid;
  logic [txrxc_pkg::CMD_W-1:0] fifo_out_data;
  logic fifo_pop;
  txrxc_fifo #(
    .WIDTH(txrxc_pkg::CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_reg_wr),
    .o_in_ready(o_reg_wr_ready),
    .i_in_data({i_reg_addr, i_reg_wdata}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  txrxc_pkg::txrxc_acc_type acc_state_q;
  txrxc_pkg::txrxc_acc_type acc_state_d;
  logic [1:0] acc_cnt_q;
  logic [CW-1:0] acc_ch_q;

  wire [7:0] wr_addr = fifo_out_data[txrxc_pkg::CMD_W-1:txrxc_pkg::DATA_W];
  wire [7:0] wr_data = fifo_out_data[txrxc_pkg::DATA_W-1:0];
  wire [CW-1:0] wr_ch = wr_addr[7:OW];
  wire [OW-1:0] wr_off = wr_addr[OW-1:0];
  wire eng_idle = (acc_state_q == txrxc_pkg::ACC_IDLE);
  assign fifo_pop = fifo_out_valid && eng_idle;
  wire wr_fire = fifo_pop;
  wire wr_scale = wr_fire && (wr_off == txrxc_pkg::OFF_SCALE);
  wire wr_access = wr_fire && (wr_off == txrxc_pkg::OFF_ACCESS);
  wire wr_ampl = wr_fire && (wr_off == txrxc_pkg::OFF_AMPL);
  wire wr_rxcfg = wr_fire && (wr_off == txrxc_pkg::OFF_RXCFG);
  wire acc_start = wr_access && wr_data[txrxc_pkg::ACC_TRIG_BIT];
  wire acc_done = (acc_state_q == txrxc_pkg::ACC_DONE);

  logic [7:0] scale_q [NUM_CH];
  logic [7:0] access_q [NUM_CH];
  logic [7:0] ampl_q [NUM_CH];
  logic [7:0] rxcfg_q [NUM_CH];

  wire [7:0] eng_access = access_q[acc_ch_q];
  wire eng_read = eng_access[txrxc_pkg::ACC_DIR_BIT];
  wire [1:0] eng_ui = eng_access[txrxc_pkg::UI_LSB +: txrxc_pkg::UI_W];
  wire [3:0] eng_sample_addr = eng_access[txrxc_pkg::SAMPLE_ADDR_LSB +: txrxc_pkg::SAMPLE_ADDR_W];
  wire [RAW-1:0] ram_addr_eng = {acc_ch_q, eng_ui, eng_sample_addr};
  wire [RAW-1:0] ram_addr_shp = {i_shaper_ch, i_shaper_ui, i_shaper_sample};
  wire ram_we = acc_done && !eng_read;
  wire [AW-1:0] ram_wdata = ampl_q[acc_ch_q][AW-1:0];
  logic [AW-1:0] ram_rdata_eng;
  logic [AW-1:0] ram_rdata_shp;

  txrxc_tram #(
    .WIDTH(AW),
    .DEPTH(txrxc_pkg::TRAM_DEPTH)
  ) u_tram (
    .i_clk(i_clk),
    .i_we(ram_we),
    .i_waddr(ram_addr_eng),
    .i_wdata(ram_wdata),
    .i_raddr_a(ram_addr_eng),
    .o_rdata_a(ram_rdata_eng),
    .i_raddr_b(ram_addr_shp),
    .o_rdata_b(ram_rdata_shp)
  );

  // Access engine: fixed latency, then the trigger bit drops
  always_comb begin
    acc_state_d = acc_state_q;
    case (acc_state_q)
      txrxc_pkg::ACC_IDLE: begin
        if (acc_start) begin
          acc_state_d = txrxc_pkg::ACC_BUSY;
        end
      end
      txrxc_pkg::ACC_BUSY: begin
        if (acc_cnt_q == ACC_CNT_LAST) begin
          acc_state_d = txrxc_pkg::ACC_DONE;
        end
      end
      txrxc_pkg::ACC_DONE: begin
        acc_state_d = txrxc_pkg::ACC_IDLE;
      end
      default: begin
        acc_state_d = txrxc_pkg::ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_state_q <= txrxc_pkg::ACC_IDLE;
      acc_cnt_q <= 2'h0;
      acc_ch_q <= '0;
    end else begin
      acc_state_q <= acc_state_d;
      acc_cnt_q <= (acc_state_q == txrxc_pkg::ACC_BUSY) ? acc_cnt_q + 2'h1 : 2'h0;
      if (acc_start) begin
        acc_ch_q <= wr_ch;
      end
    end
  end

  assign o_access_busy = !eng_idle;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    wire sel = (wr_ch == CW'(ch));
    wire done_here = acc_done && (acc_ch_q == CW'(ch));
    wire [7:0] rxcfg = rxcfg_q[ch];
    wire [1:0] md = rxcfg[txrxc_pkg::RX_MD_LSB +: 2];
    wire pwr_down = rxcfg[txrxc_pkg::RX_OFF_BIT];
    wire inv = rxcfg[txrxc_pkg::RX_INV_BIT];
    wire fall_sel = rxcfg[txrxc_pkg::RX_EDGE_BIT];
    wire slicer = (md == txrxc_pkg::RXMD_SLICER);
    wire single_mode = !md[1];
    logic rclk_prev_q;
    wire rise = i_rx_recovered_clock[ch] && !rclk_prev_q;
    wire fall = !i_rx_recovered_clock[ch] && rclk_prev_q;
    wire upd = slicer ? 1'b1 : (fall_sel ? fall : rise);
    wire single_src = (md == txrxc_pkg::RXMD_HDB3) ? i_rx_nrz_hdb3[ch]
                                                   : i_rx_nrz_ami[ch];
    wire pos_src = slicer ? i_rx_slicer_pos[ch] : i_rx_cdr_pos[ch];
    wire neg_src = slicer ? i_rx_slicer_neg[ch] : i_rx_cdr_neg[ch];
    wire single_nxt = (single_mode && single_src) ^ inv;
    wire pos_nxt = (!single_mode && pos_src) ^ inv;
    wire neg_nxt = (!single_mode && neg_src) ^ inv;
    logic single_q;
    logic pos_q;
    logic neg_q;

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        scale_q[ch] <= txrxc_pkg::RST_SCALE;
        access_q[ch] <= txrxc_pkg::RST_ACCESS;
        ampl_q[ch] <= txrxc_pkg::RST_AMPL;
        rxcfg_q[ch] <= txrxc_pkg::RST_RXCFG;
      end else begin
        if (wr_scale && sel) begin
          scale_q[ch] <= wr_data & txrxc_pkg::MASK_SCALE;
        end
        if (wr_access && sel) begin
          access_q[ch] <= wr_data & txrxc_pkg::MASK_ACCESS;
        end else if (done_here) begin
          access_q[ch][txrxc_pkg::ACC_TRIG_BIT] <= 1'b0;
        end
        if (wr_ampl && sel) begin
          ampl_q[ch] <= wr_data & txrxc_pkg::MASK_AMPL;
        end else if (done_here && eng_read) begin
          ampl_q[ch] <= {1'b0, ram_rdata_eng};
        end
        if (wr_rxcfg && sel) begin
          rxcfg_q[ch] <= wr_data & txrxc_pkg::MASK_RXCFG;
        end
      end
    end

    // Powered-down receiver parks its outputs low regardless of inversion
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        rclk_prev_q <= 1'b0;
        single_q <= 1'b0;
        pos_q <= 1'b0;
        neg_q <= 1'b0;
      end else begin
        rclk_prev_q <= i_rx_recovered_clock[ch];
        if (pwr_down) begin
          single_q <= 1'b0;
          pos_q <= 1'b0;
          neg_q <= 1'b0;
        end else if (upd) begin
          single_q <= single_nxt;
          pos_q <= pos_nxt;
          neg_q <= neg_nxt;
        end
      end
    end

    assign o_rx_power_down[ch] = pwr_down;
    assign o_rx_decode_mode[2*ch +: 2] = md;
    assign o_rx_single_rail_out[ch] = single_q;
    assign o_rx_dual_rail_out_pos[ch] = pos_q;
    assign o_rx_dual_rail_out_neg[ch] = neg_q;
  end

  // Reads see registers only; writes still queued are not reflected yet
  wire [CW-1:0] rd_ch = i_reg_addr[7:OW];
  wire [OW-1:0] rd_off = i_reg_addr[OW-1:0];
  wire [7:0] rd_mux = (rd_off == txrxc_pkg::OFF_SCALE) ? scale_q[rd_ch] :
                      (rd_off == txrxc_pkg::OFF_ACCESS) ? access_q[rd_ch] :
                      (rd_off == txrxc_pkg::OFF_AMPL) ? ampl_q[rd_ch] :
                      (rd_off == txrxc_pkg::OFF_RXCFG) ? rxcfg_q[rd_ch] : 8'h00;

  wire [5:0] shp_scale = scale_q[i_shaper_ch][txrxc_pkg::SCALE_W-1:0];
  wire shp_t1 = i_tx_template_t1[i_shaper_ch];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rdata_valid <= 1'b0;
      o_shaper_amplitude <= 7'h00;
    end else begin
      o_reg_rdata_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
      o_shaper_amplitude <= scale_amp(ram_rdata_shp, shp_scale, shp_t1);
    end
  end
endmodule
`default_nettype wire

/* hw/txrxc_tram.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_tram #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 512
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr_a,
  output logic [WIDTH-1:0] o_rdata_a,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr_b,
  output logic [WIDTH-1:0] o_rdata_b
);
  if (DEPTH < 2) begin : g_chk
    $error("Template RAM depth too small");
  end
  // No reset: template contents are undefined until software loads them
  logic [WIDTH-1:0] mem_q [DEPTH];
  assign o_rdata_a = mem_q[i_raddr_a];
  assign o_rdata_b = mem_q[i_raddr_b];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

/* tb/txrxc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_bench;
  logic clk, rst, wr, rd, ready, valid, busy, v;
  logic [7:0] addr, wdata, rdata, d, e, t1, rclk, hdb3, ami, cpos, cneg, spos, sneg;
  logic [7:0] pd, single, dpos, dneg;
  logic [2:0] sh_ch;
  logic [1:0] sh_ui;
  logic [3:0] sh_s;
  logic [6:0] shp;
  logic [15:0] mode;
  logic [15:0] tt [5] = '{16'h0064, 16'hFFFF, 16'h32E4, 16'h3209, 16'h2AB7};
  logic [23:0] sx [7] = '{24'h102164, 24'h113664, 24'h113766, 24'h102267, 24'h102061,
    24'h70227F, 24'h71357C};
  int n_mismatch = 0;
  int checks = 0;
  int n_refused = 0;
  txrxc_top i_txrxc_top (.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_wr_ready(ready), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rdata_valid(valid), .o_access_busy(busy),
    .i_shaper_ch(sh_ch), .i_shaper_ui(sh_ui), .i_shaper_sample(sh_s),
    .i_tx_template_t1(t1), .o_shaper_amplitude(shp), .i_rx_recovered_clock(rclk),
    .i_rx_nrz_hdb3(hdb3), .i_rx_nrz_ami(ami), .i_rx_cdr_pos(cpos), .i_rx_cdr_neg(cneg),
    .i_rx_slicer_pos(spos), .i_rx_slicer_neg(sneg), .o_rx_power_down(pd),
    .o_rx_decode_mode(mode), .o_rx_single_rail_out(single),
    .o_rx_dual_rail_out_pos(dpos), .o_rx_dual_rail_out_neg(dneg));
  txrxc_host i_txrxc_host (.i_clk(clk), .i_wr_ready(ready), .i_rdata(rdata),
    .i_rdata_valid(valid), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (ready === 1'b0) n_refused++;
  task automatic chk(input logic [7:0] got, input logic [7:0] x, input string w);
    checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, x);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] x);
    i_txrxc_host.write_reg(a, x);
  endtask
  task automatic idle(input int n);
    i_txrxc_host.idle(n);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x, input string w);
    i_txrxc_host.read_reg(a, d, v);
    chk({7'h00, v}, 8'h01, "read valid");
    chk(d, x, w);
  endtask
  task automatic pulse;
    rclk[0] = 1'b1;
    idle(2);
    rclk[0] = 1'b0;
    idle(2);
  endtask
  // Only trigger words are queued here, so four idle cycles mean empty
  task automatic drain;
    int q;
    q = 0;
    idle(0);
    for (int i = 0; i < 600 && q < 4; i++) begin
      @(negedge clk);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    t1 = 8'hFF;
    rclk = 8'h00;
    hdb3 = 8'hFF;
    ami = 8'h00;
    cpos = 8'hFF;
    cneg = 8'h00;
    spos = 8'h00;
    sneg = 8'hFF;
    {sh_ch, sh_ui, sh_s} = 9'h000;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t1 = 8'h00;
    for (int c = 0; c < 8; c += 7) begin
      rchk({c[2:0], 5'h04}, 8'h21, "scale reset");
      rchk({c[2:0], 5'h05}, 8'h00, "access reset");
      rchk({c[2:0], 5'h07}, 8'h00, "rx reset");
    end
    wr8(8'h64, 8'hFF);
    wr8(8'hA7, 8'hE3);
    wr8(8'h08, 8'h5A);
    idle(3);
    rchk(8'h64, 8'h3F, "scale mask");
    rchk(8'h44, 8'h21, "other channel");
    rchk(8'hA7, 8'h03, "rx mask");
    rchk(8'h08, 8'h00, "unmapped");
    chk({6'h00, mode[11:10]}, 8'h03, "ch5 mode");
    for (int k = 0; k < 5; k++) begin
      wr8({tt[k][15:13], 5'h06}, {1'b0, tt[k][6:0]});
      i_txrxc_host.access(tt[k][15:13], {2'b10, tt[k][12:7]});
    end
    for (int k = 0; k < 5; k++) begin
      wr8({tt[k][15:13], 5'h06}, 8'h00);
      i_txrxc_host.access(tt[k][15:13], {2'b11, tt[k][12:7]});
      rchk({tt[k][15:13], 5'h06}, {1'b0, tt[k][6:0]}, "template");
    end
    for (int k = 0; k < 7; k++) begin
      t1[sx[k][22:20]] = sx[k][16];
      wr8({sx[k][22:20], 5'h04}, sx[k][15:8]);
      idle(3);
      sh_ch = sx[k][22:20];
      {sh_ui, sh_s} = (sh_ch == 3'd1) ? 6'h25 : 6'h3F;
      idle(1);
      chk({1'b0, shp}, sx[k][7:0], "scaled sample");
    end
    for (int m = 0; m < 8; m++) begin
      wr8(8'h07, {4'h0, m[2], 1'b0, m[1:0]});
      idle(3);
      pulse();
      e = {5'h00, (m[1:0] == 0) ^ m[2], (m[1:0] == 2) ^ m[2], (m[1:0] == 3) ^ m[2]};
      chk({5'h00, single[0], dpos[0], dneg[0]}, e, "rx rails");
      chk({6'h00, mode[1:0]}, {6'h00, m[1:0]}, "mode out");
    end
    hdb3 = 8'h00;
    wr8(8'h07, 8'h04);
    idle(3);
    pulse();
    hdb3 = 8'hFF;
    rclk[0] = 1'b1;
    idle(3);
    chk({7'h00, single[0]}, 8'h00, "rise ignored");
    rclk[0] = 1'b0;
    idle(3);
    chk({7'h00, single[0]}, 8'h01, "fall taken");
    wr8(8'h07, 8'h07);
    idle(3);
    spos = 8'hFF;
    idle(3);
    chk({7'h00, dpos[0]}, 8'h01, "slicer free");
    wr8(8'h07, 8'h18);
    idle(3);
    chk({3'h0, pd[1:0], single[0], dpos[0], dneg[0]}, 8'h08, "power down");
    for (int k = 0; k < 60; k++) wr8(8'h85, 8'h80);
    drain();
    chk({6'h00, n_refused > 0, ready}, 8'h03, "fifo fill drain");
    rchk(8'h85, 8'h00, "trigger cleared");
    complete_run();
  end
endmodule
`default_nettype wire

/* tb/txrxc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_host (
  input wire logic i_clk,
  input wire logic i_wr_ready,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Write stays raised on return so a burst pushes one word per cycle
  task automatic write_reg(input logic [7:0] a, input logic [7:0] x);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = x;
    o_wr = 1'b1;
    while (!i_wr_ready) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  task automatic idle(input int n);
    @(negedge i_clk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    repeat (n) @(negedge i_clk);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] x, output logic vld);
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    x = i_rdata;
    vld = i_rdata_valid;
  endtask
  // Reads bypass the write queue, so poll only once the trigger has landed
  task automatic access(input logic [2:0] ch, input logic [7:0] ctrl);
    logic [7:0] x;
    logic vld;
    write_reg({ch, 5'h05}, ctrl);
    idle(2);
    x = 8'h80;
    for (int i = 0; i < 40 && x[7] !== 1'b0; i++) read_reg({ch, 5'h05}, x, vld);
  endtask
endmodule
`default_nettype wire

/* tb/txrxc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module txrxc_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic o_reg_wr_ready,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rdata_valid,
  input wire logic o_access_busy,
  input wire logic [7:0] i_rx_slicer_pos,
  input wire logic [7:0] i_rx_slicer_neg,
  input wire logic [7:0] o_rx_power_down,
  input wire logic [15:0] o_rx_decode_mode,
  input wire logic [7:0] o_rx_single_rail_out,
  input wire logic [7:0] o_rx_dual_rail_out_pos,
  input wire logic [7:0] o_rx_dual_rail_out_neg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_read_latency: assert property (i_reg_rd |=> o_reg_rdata_valid)
    else $error("read answer missing");
  a_valid_cause: assert property (o_reg_rdata_valid |-> $past(i_reg_rd))
    else $error("read answer without request");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_trigger_starts: assert property ((i_reg_wr && o_reg_wr_ready && i_reg_addr[4:0] == 5'h05
    && i_reg_wdata[7]) |-> ##[1:300] o_access_busy)
    else $error("trigger write never started access");
  a_busy_span: assert property ($rose(o_access_busy) |->
    o_access_busy [*3] ##1 !o_access_busy)
    else $error("access busy span wrong");
  a_refuse_cause: assert property ($fell(o_reg_wr_ready) |-> $past(i_reg_wr))
    else $error("write port refused with no write");
  // Outputs are registered, so power-down must have stood for a cycle first
  a_power_quiet: assert property ((o_rx_power_down & $past(o_rx_power_down) &
    (o_rx_single_rail_out | o_rx_dual_rail_out_pos | o_rx_dual_rail_out_neg)) == 8'h00)
    else $error("powered down receiver drives data");
  // Both rails share one invert bit, so the invert setting cancels out
  a_slicer_pair: assert property (($past(o_rx_decode_mode[1:0]) == 2'b11 &&
    o_rx_decode_mode[1:0] == 2'b11 && !o_rx_power_down[0] && !$past(o_rx_power_down[0]))
    |-> ((o_rx_dual_rail_out_pos[0] ^ $past(i_rx_slicer_pos[0])) ==
    (o_rx_dual_rail_out_neg[0] ^ $past(i_rx_slicer_neg[0]))))
    else $error("slicer rails not following slicer data");
endmodule
bind txrxc_top txrxc_monitor i_txrxc_monitor (.*);
`default_nettype wire
